/* File: logic/tal_pkg.sv */
// constants and register map shared by the totalizer and alarm logic
package tal_pkg;
  // ==========================================
  // register map (byte offsets)
  localparam logic [7:0] REG_CTRL      = 8'h00;
  localparam logic [7:0] REG_SCALE     = 8'h04;
  localparam logic [7:0] REG_CUTOUT    = 8'h08;
  localparam logic [7:0] REG_INPUT     = 8'h0c;
  localparam logic [7:0] REG_TOTAL     = 8'h10;
  localparam logic [7:0] REG_SP1       = 8'h14;
  localparam logic [7:0] REG_SP2       = 8'h18;
  localparam logic [7:0] REG_HYST1     = 8'h1c;
  localparam logic [7:0] REG_HYST2     = 8'h20;
  localparam logic [7:0] REG_STATUS    = 8'h24;
  localparam logic [7:0] REG_IRQ_STAT  = 8'h28;
  localparam logic [7:0] REG_IRQ_EN    = 8'h2c;
  localparam logic [7:0] REG_IRQ_CLR   = 8'h30;
  localparam logic [7:0] REG_CMD       = 8'h34;
  // ==========================================
  // control fields
  localparam int CTRL_TB_LSB   = 0;   // 2 bits period select
  localparam int CTRL_TDP_LSB  = 2;   // 3 bits total decimal places
  localparam int CTRL_IDP_LSB  = 5;   // 3 bits input decimal places
  localparam int CTRL_HIGH1    = 8;
  localparam int CTRL_HIGH2    = 9;
  localparam int CTRL_LATCH1   = 10;
  localparam int CTRL_LATCH2   = 11;
  localparam int CTRL_SRC1     = 12;  // 1 = total
  localparam int CTRL_SRC2     = 13;
  localparam int CTRL_TRACK    = 14;
  localparam int CTRL_DISPALM  = 15;
  localparam int CTRL_SERIAL   = 16;  // 1 = writes come from the serial link
  localparam int CTRL_TOT_OPT  = 17;  // totalizer option present
  localparam logic [31:0] CTRL_RESET = 32'h0002_0100;
  // command bits
  localparam int CMD_CLR_LATCH = 0;
  localparam int CMD_CLR_TOTAL = 1;
  // interrupt bits
  localparam int IRQ_OVF   = 0;
  localparam int IRQ_AL1   = 1;
  localparam int IRQ_AL2   = 2;
  localparam int IRQ_W     = 3;
  // ==========================================
  // numeric limits
  localparam logic signed [31:0] TOT_MAX  = 32'sd999999;
  localparam logic signed [31:0] TOT_MIN  = -32'sd99999;
  localparam logic signed [31:0] TOT_SPAN = 32'sd1099999;
  localparam logic signed [31:0] HYST_MIN = 32'sd1;
  localparam logic signed [31:0] HYST_MAX = 32'sd99999;
  localparam logic [15:0] SCALE_ONE = 16'h03e8;  // 1.000 in thousandths
  localparam int SCALE_DIV = 1000;
  localparam int TB_SEC  = 1;
  localparam int TB_MIN  = 60;
  localparam int TB_HOUR = 3600;
  // ==========================================
  // timing
  localparam int CLK_HZ          = 20_000_000;
  localparam int SECOND_CYC      = CLK_HZ;
  localparam int DISP_PER_SEC_X2 = 5;          // 2 1/2 per second
  localparam int DISP_CYC        = (2 * CLK_HZ) / DISP_PER_SEC_X2;
  localparam int FLASH_S         = 5;          // lower end of 5 to 10 s
  localparam int FLASH_CYC       = FLASH_S * CLK_HZ;
endpackage : tal_pkg

/* File: logic/tal_alarm.sv */
// one setpoint alarm with hysteresis, high/low action and latching
`timescale 1ns/1ps
module tal_alarm (
  // clock and reset
  input  wire logic               hclk,
  input  wire logic               hresetn,
  input  wire logic               ce,
  // configuration
  input  wire logic               high_act,
  input  wire logic               latch_en,
  input  wire logic signed [31:0] setpoint,
  input  wire logic signed [31:0] hyst,
  input  wire logic signed [31:0] source,
  // manual reset
  input  wire logic               clear_latch,
  input  wire logic               force_off,
  // state
  output logic                    active
);
  logic signed [31:0] h_eff;
  logic               trip;
  logic               release_ok;
  logic               active_q;

  // latching alarms ignore hysteresis entirely
  assign h_eff      = latch_en ? 32'sh0 : hyst;
  assign trip       = high_act ? (source > setpoint) : (source < setpoint);
  assign release_ok = high_act ? (source < setpoint - h_eff) : (source > setpoint + h_eff);
  assign active     = active_q;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      active_q <= 1'b0;
    end else if (ce) begin
      if (force_off) begin
        active_q <= 1'b0;
      end else if (trip) begin
        active_q <= 1'b1;
      end else if (latch_en) begin
        if (clear_latch) begin
          active_q <= 1'b0;
        end
      end else if (release_ok) begin
        active_q <= 1'b0;
      end
    end
  end
endmodule : tal_alarm

/* File: logic/tal_top.sv */
// totalizer and two-setpoint alarm logic behind an ahb-lite register slave
//
// The AHB-Lite interface to the registers and the address map are this design's own decisions.
`timescale 1ns/1ps
module tal_top #(
  parameter int SECOND_CYC = tal_pkg::SECOND_CYC,
  parameter int DISP_CYC   = tal_pkg::DISP_CYC,
  parameter int FLASH_CYC  = tal_pkg::FLASH_CYC
) (
  // clock, reset, enable
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        ce,
  // ahb-lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // pins
  input  wire logic        front_panel_lockout_pin,
  input  wire logic        remote_input_one,
  input  wire logic        remote_input_two,
  // indicators
  output logic             alarm1_out,
  output logic             alarm2_out,
  output logic             overflow_flash,
  output logic             display_strobe,
  output logic             alarm_msg_flash,
  output logic      [1:0]  alarm_msg_sel,
  output logic signed [31:0] display_total,
  output logic             irq
);
  // ==========================================
  // pin synchronisers
  logic [2:0] pin_s1_q;
  logic [2:0] pin_s2_q;
  logic [2:0] pin_prev_q;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pin_s1_q   <= 3'h7;
      pin_s2_q   <= 3'h7;
      pin_prev_q <= 3'h7;
    end else if (ce) begin
      pin_s1_q   <= {remote_input_two, remote_input_one, front_panel_lockout_pin};
      pin_s2_q   <= pin_s1_q;
      pin_prev_q <= pin_s2_q;
    end
  end
  logic lockout_low;
  logic remote_fall;
  assign lockout_low = ~pin_s2_q[0];
  // a falling edge on either remote input clears latched alarms
  assign remote_fall = |(pin_prev_q[2:1] & ~pin_s2_q[2:1]);

  // ==========================================
  // ahb-lite slave
  logic        wr_pend_q;
  logic [7:0]  addr_q;
  logic        take;
  assign take = hsel & hready & htrans[1];
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_q <= 1'b0;
      addr_q    <= 8'h00;
    end else if (ce) begin
      wr_pend_q <= take & hwrite;
      if (take) begin
        addr_q <= haddr[7:0];
      end
    end
  end
  logic wr_en;
  assign wr_en = wr_pend_q & ce;

  // ==========================================
  // configuration registers
  logic        [31:0] ctrl_q;
  logic        [15:0] scale_q;
  logic signed [31:0] cutout_q;
  logic signed [31:0] input_q;
  logic signed [31:0] sp1_q;
  logic signed [31:0] sp2_q;
  logic signed [31:0] hyst1_q;
  logic signed [31:0] hyst2_q;
  logic        [tal_pkg::IRQ_W-1:0] irq_en_q;
  logic signed [31:0] wval;
  logic signed [31:0] sp_clip;
  logic signed [31:0] h_clip;
  logic signed [31:0] sp1_tracked;
  logic               track_now;
  assign wval    = signed'(hwdata);
  assign sp_clip = (wval > tal_pkg::TOT_MAX) ? tal_pkg::TOT_MAX :
                   (wval < tal_pkg::TOT_MIN) ? tal_pkg::TOT_MIN : wval;
  assign h_clip  = (wval > tal_pkg::HYST_MAX) ? tal_pkg::HYST_MAX :
                   (wval < tal_pkg::HYST_MIN) ? tal_pkg::HYST_MIN : wval;
  // serial edits always track, panel edits only in lockout mode
  assign track_now = ctrl_q[tal_pkg::CTRL_TRACK] &
                     (ctrl_q[tal_pkg::CTRL_SERIAL] | lockout_low);
  assign sp1_tracked = sp1_q + (sp_clip - sp2_q);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_q   <= tal_pkg::CTRL_RESET;
      scale_q  <= tal_pkg::SCALE_ONE;
      cutout_q <= 32'sh0;
      input_q  <= 32'sh0;
      sp1_q    <= 32'sh0;
      sp2_q    <= 32'sh0;
      hyst1_q  <= tal_pkg::HYST_MIN;
      hyst2_q  <= tal_pkg::HYST_MIN;
      irq_en_q <= '0;
    end else if (wr_en) begin
      case (addr_q)
        tal_pkg::REG_CTRL:   ctrl_q   <= hwdata;
        tal_pkg::REG_SCALE:  scale_q  <= hwdata[15:0];
        tal_pkg::REG_CUTOUT: cutout_q <= wval;
        tal_pkg::REG_INPUT:  input_q  <= wval;
        tal_pkg::REG_SP1:    sp1_q    <= sp_clip;
        tal_pkg::REG_SP2: begin
          sp2_q <= sp_clip;
          if (track_now) begin
            sp1_q <= sp1_tracked;
          end
        end
        // latched alarms refuse hysteresis writes
        tal_pkg::REG_HYST1: if (!ctrl_q[tal_pkg::CTRL_LATCH1]) hyst1_q <= h_clip;
        tal_pkg::REG_HYST2: if (!ctrl_q[tal_pkg::CTRL_LATCH2]) hyst2_q <= h_clip;
        tal_pkg::REG_IRQ_EN: irq_en_q <= hwdata[tal_pkg::IRQ_W-1:0];
        default: ;
      endcase
    end
  end
  logic cmd_clr_latch;
  logic cmd_clr_total;
  assign cmd_clr_latch = wr_en & (addr_q == tal_pkg::REG_CMD) & hwdata[tal_pkg::CMD_CLR_LATCH];
  assign cmd_clr_total = wr_en & (addr_q == tal_pkg::REG_CMD) & hwdata[tal_pkg::CMD_CLR_TOTAL];

  // ==========================================
  // decimal weights and period divisor
  function automatic logic signed [31:0] dp_weight(input logic [2:0] places);
    case (places)
      3'd0:    dp_weight = 32'sd1;
      3'd1:    dp_weight = 32'sd10;
      3'd2:    dp_weight = 32'sd100;
      3'd3:    dp_weight = 32'sd1000;
      default: dp_weight = 32'sd10000;
    endcase
  endfunction : dp_weight
  logic signed [31:0] tb_div;
  always_comb begin
    case (ctrl_q[tal_pkg::CTRL_TB_LSB +: 2])
      2'd1:    tb_div = 32'(tal_pkg::TB_MIN);
      2'd2:    tb_div = 32'(tal_pkg::TB_HOUR);
      default: tb_div = 32'(tal_pkg::TB_SEC);
    endcase
  end

  // ==========================================
  // per-second increment; the 64-bit path avoids overflow of input*scale*weight
  logic signed [63:0] numer;
  logic signed [63:0] denom;
  logic signed [63:0] incr;
  logic signed [31:0] tdp_w;
  logic signed [31:0] idp_w;
  assign tdp_w = dp_weight(ctrl_q[tal_pkg::CTRL_TDP_LSB +: 3]);
  assign idp_w = dp_weight(ctrl_q[tal_pkg::CTRL_IDP_LSB +: 3]);
  assign numer = 64'(input_q) * 64'(signed'({16'h0, scale_q})) * 64'(tdp_w);
  assign denom = 64'(tb_div) * 64'(idp_w) * 64'(tal_pkg::SCALE_DIV);
  assign incr  = numer / denom;

  // ==========================================
  // one second tick and totalizer
  logic [31:0] sec_cnt_q;
  logic        sec_tick;
  assign sec_tick = (sec_cnt_q == 32'(SECOND_CYC - 1));
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sec_cnt_q <= 32'h0;
    end else if (ce) begin
      sec_cnt_q <= sec_tick ? 32'h0 : sec_cnt_q + 32'h1;
    end
  end

  logic signed [31:0] total_q;
  logic               ovf_q;
  logic signed [31:0] sum;
  assign sum = total_q + incr[31:0];
  logic ovf_evt;
  assign ovf_evt = ce & sec_tick & (input_q >= cutout_q) & ((sum > tal_pkg::TOT_MAX) | (sum < tal_pkg::TOT_MIN));
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      total_q <= 32'sh0;
      ovf_q   <= 1'b0;
    end else if (ce) begin
      if (cmd_clr_total) begin
        total_q <= 32'sh0;
        ovf_q   <= 1'b0;
      end else if (sec_tick && input_q >= cutout_q) begin
        // signed sum lets a negative input count back down
        if (sum > tal_pkg::TOT_MAX) begin
          total_q <= sum - tal_pkg::TOT_SPAN;
          ovf_q   <= ~ovf_q;
        end else if (sum < tal_pkg::TOT_MIN) begin
          total_q <= sum + tal_pkg::TOT_SPAN;
          ovf_q   <= ~ovf_q;
        end else begin
          total_q <= sum;
        end
      end
    end
  end

  // ==========================================
  // display refresh at 2.5 Hz, independent of the period select
  logic [31:0] disp_cnt_q;
  logic        disp_tick;
  logic        flash_ph_q;
  assign disp_tick = (disp_cnt_q == 32'(DISP_CYC - 1));
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      disp_cnt_q     <= 32'h0;
      display_strobe <= 1'b0;
      display_total  <= 32'sh0;
      flash_ph_q     <= 1'b0;
      overflow_flash <= 1'b0;
    end else if (ce) begin
      disp_cnt_q     <= disp_tick ? 32'h0 : disp_cnt_q + 32'h1;
      display_strobe <= disp_tick;
      if (disp_tick) begin
        display_total  <= total_q;
        flash_ph_q     <= ~flash_ph_q;
        overflow_flash <= ovf_q & ~flash_ph_q;
      end
    end
  end

  // ==========================================
  // alarms
  logic signed [31:0] src1;
  logic signed [31:0] src2;
  logic               al1;
  logic               al2;
  logic               clr_latch;
  // without the totalizer option the source is always the input
  assign src1 = (ctrl_q[tal_pkg::CTRL_SRC1] & ctrl_q[tal_pkg::CTRL_TOT_OPT]) ? total_q : input_q;
  assign src2 = (ctrl_q[tal_pkg::CTRL_SRC2] & ctrl_q[tal_pkg::CTRL_TOT_OPT]) ? total_q : input_q;
  assign clr_latch = cmd_clr_latch | remote_fall;

  tal_alarm u_al1 (
    .hclk        (hclk),
    .hresetn     (hresetn),
    .ce          (ce),
    .high_act    (ctrl_q[tal_pkg::CTRL_HIGH1]),
    .latch_en    (ctrl_q[tal_pkg::CTRL_LATCH1]),
    .setpoint    (sp1_q),
    .hyst        (hyst1_q),
    .source      (src1),
    .clear_latch (clr_latch),
    .force_off   (1'b0),
    .active      (al1)
  );
  tal_alarm u_al2 (
    .hclk        (hclk),
    .hresetn     (hresetn),
    .ce          (ce),
    .high_act    (ctrl_q[tal_pkg::CTRL_HIGH2]),
    .latch_en    (ctrl_q[tal_pkg::CTRL_LATCH2]),
    .setpoint    (sp2_q),
    .hyst        (hyst2_q),
    .source      (src2),
    .clear_latch (clr_latch),
    .force_off   (1'b0),
    .active      (al2)
  );

  // ==========================================
  // alarm message flashing
  logic [31:0] flash_cnt_q;
  logic        flash_tick;
  assign flash_tick = (flash_cnt_q == 32'(FLASH_CYC - 1));
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      flash_cnt_q     <= 32'h0;
      alarm_msg_flash <= 1'b0;
      alarm_msg_sel   <= 2'b00;
      alarm1_out      <= 1'b0;
      alarm2_out      <= 1'b0;
    end else if (ce) begin
      alarm1_out <= al1;
      alarm2_out <= al2;
      if (!(al1 | al2) || !ctrl_q[tal_pkg::CTRL_DISPALM]) begin
        flash_cnt_q     <= 32'h0;
        alarm_msg_flash <= 1'b0;
        alarm_msg_sel   <= 2'b00;
      end else begin
        flash_cnt_q     <= flash_tick ? 32'h0 : flash_cnt_q + 32'h1;
        alarm_msg_flash <= flash_tick;
        alarm_msg_sel   <= {al2, al1};
      end
    end
  end

  // ==========================================
  // interrupts: set wins over a same-cycle clear
  logic [tal_pkg::IRQ_W-1:0] irq_stat_q;
  logic [tal_pkg::IRQ_W-1:0] irq_set;
  logic [tal_pkg::IRQ_W-1:0] irq_clr;
  logic                      al1_prev_q;
  logic                      al2_prev_q;
  assign irq_set = {al2 & ~al2_prev_q, al1 & ~al1_prev_q, ovf_evt};
  assign irq_clr = (wr_en && addr_q == tal_pkg::REG_IRQ_CLR) ? hwdata[tal_pkg::IRQ_W-1:0] : '0;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_stat_q <= '0;
      al1_prev_q <= 1'b0;
      al2_prev_q <= 1'b0;
      irq        <= 1'b0;
    end else if (ce) begin
      al1_prev_q <= al1;
      al2_prev_q <= al2;
      irq_stat_q <= (irq_stat_q & ~irq_clr) | irq_set;
      irq        <= |(((irq_stat_q & ~irq_clr) | irq_set) & irq_en_q);
    end
  end

  // ==========================================
  // read data; zero-wait, always okay
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0;
    end else if (ce) begin
      if (take && !hwrite) begin
        case (haddr[7:0])
          tal_pkg::REG_CTRL:     hrdata <= ctrl_q;
          tal_pkg::REG_SCALE:    hrdata <= {16'h0, scale_q};
          tal_pkg::REG_CUTOUT:   hrdata <= cutout_q;
          tal_pkg::REG_INPUT:    hrdata <= input_q;
          tal_pkg::REG_TOTAL:    hrdata <= total_q;
          tal_pkg::REG_SP1:      hrdata <= sp1_q;
          tal_pkg::REG_SP2:      hrdata <= sp2_q;
          tal_pkg::REG_HYST1:    hrdata <= hyst1_q;
          tal_pkg::REG_HYST2:    hrdata <= hyst2_q;
          tal_pkg::REG_STATUS:   hrdata <= {28'h0, lockout_low, al2, al1, ovf_q};
          tal_pkg::REG_IRQ_STAT: hrdata <= {29'h0, irq_stat_q};
          tal_pkg::REG_IRQ_EN:   hrdata <= {29'h0, irq_en_q};
          default:               hrdata <= 32'h0;
        endcase
      end
    end
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
  end
endmodule : tal_top

/* File: testbench/tal_panel_model.sv */
// model of the operator panel pins: lockout level and remote clear pulses
`timescale 1ns/1ps
module tal_panel_model #(
  parameter int HOLD_CYC = 6
) (
  // clock, reset
  input  wire logic clk,
  input  wire logic hresetn,
  // requests from the bench
  input  wire logic lock_req,
  input  wire logic clr_one_req,
  input  wire logic clr_two_req,
  // pins
  output logic      front_panel_lockout_pin,
  output logic      remote_input_one,
  output logic      remote_input_two
);
  logic [7:0] cnt1_q;
  logic [7:0] cnt2_q;
  // ==========================================
  // pins idle high; a clear is a low pulse held long enough to pass the synchroniser
  always_ff @(posedge clk or negedge hresetn) begin
    if (!hresetn) begin
      front_panel_lockout_pin <= 1'b1;
      cnt1_q                  <= 8'h00;
      cnt2_q                  <= 8'h00;
    end else begin
      front_panel_lockout_pin <= !lock_req;
      cnt1_q <= clr_one_req ? 8'(HOLD_CYC) : (cnt1_q != 8'h00 ? cnt1_q - 8'h01 : cnt1_q);
      cnt2_q <= clr_two_req ? 8'(HOLD_CYC) : (cnt2_q != 8'h00 ? cnt2_q - 8'h01 : cnt2_q);
    end
  end
  assign remote_input_one = (cnt1_q == 8'h00);
  assign remote_input_two = (cnt2_q == 8'h00);
endmodule : tal_panel_model

/* File: testbench/tal_top_chk.sv */
// port-level assertions for the totalizer and alarm block
`timescale 1ns/1ps
module tal_top_chk #(
  parameter int DISP_CYC = 8
) (
  // clock, reset, enable
  input wire logic               hclk,
  input wire logic               hresetn,
  input wire logic               ce,
  // bus answer
  input wire logic               hreadyout,
  input wire logic               hresp,
  // indicators
  input wire logic               alarm1_out,
  input wire logic               overflow_flash,
  input wire logic               display_strobe,
  input wire logic               alarm_msg_flash,
  input wire logic [1:0]         alarm_msg_sel,
  input wire logic signed [31:0] display_total
);
  logic [31:0] gap_q;
  logic        seen_q;
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // ==========================================
  // cycles since the last refresh strobe, frozen with ce like the design
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      gap_q  <= 32'h0;
      seen_q <= 1'b0;
    end else if (display_strobe) begin
      gap_q  <= 32'h0;
      seen_q <= 1'b1;
    end else if (ce) begin
      gap_q  <= gap_q + 32'h1;
    end
  end
  // ==========================================
  resp_okay_a: assert property (hresp == 1'b0) else $error("slave response not okay");
  zero_wait_a: assert property (hreadyout == 1'b1) else $error("slave inserted a wait");
  refresh_rate_a: assert property (display_strobe && seen_q && ce |-> gap_q == DISP_CYC - 1)
    else $error("refresh strobe spacing wrong");
  strobe_pulse_a: assert property (display_strobe && ce |=> !display_strobe)
    else $error("refresh strobe longer than one cycle");
  total_hold_a: assert property ($changed(display_total) |-> display_strobe || $past(display_strobe))
    else $error("shown total changed between refreshes");
  flash_sync_a: assert property ($changed(overflow_flash) |-> display_strobe || $past(display_strobe))
    else $error("overflow flash changed off the refresh");
  msg_names_a: assert property (alarm_msg_flash |-> alarm_msg_sel != 2'b00)
    else $error("alarm message with no alarm named");
  msg_spacing_a: assert property (alarm_msg_flash && ce |=> !alarm_msg_flash [*8])
    else $error("alarm message repeated too soon");
  freeze_alarm_a: assert property (!ce ##1 !ce |-> $stable(alarm1_out))
    else $error("alarm changed while frozen");
endmodule : tal_top_chk

bind tal_top tal_top_chk #(.DISP_CYC(DISP_CYC)) i_tal_top_chk (
  .hclk(hclk), .hresetn(hresetn), .ce(ce), .hreadyout(hreadyout), .hresp(hresp),
  .alarm1_out(alarm1_out), .overflow_flash(overflow_flash), .display_strobe(display_strobe),
  .alarm_msg_flash(alarm_msg_flash), .alarm_msg_sel(alarm_msg_sel), .display_total(display_total)
);

/* File: testbench/tb_tal_top.sv */
// register-level bench for the totalizer and alarm block
`timescale 1ns/1ps
module tb_tal_top;
  localparam int SEC = 20;
  logic hclk = 1'b0, hresetn = 1'b0, ce = 1'b1, hsel = 1'b0, hwrite = 1'b0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, v;
  logic [1:0]  htrans = 2'h0, sel;
  logic lock_req = 1'b0, clr1 = 1'b0, clr2 = 1'b0, pin_n, ri1, ri2, hready, hresp;
  logic a1, a2, ovf_fl, strobe, msg, irq, seen;
  logic signed [31:0] dtot;
  int fails = 0, compares = 0, cyc = 0, wraps = 0;
  initial forever #25 hclk = ~hclk;
  tal_top #(.SECOND_CYC(SEC), .DISP_CYC(8), .FLASH_CYC(50)) i_tal_top (
    .hclk(hclk), .hresetn(hresetn), .ce(ce), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(3'h2), .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hreadyout(hready), .hresp(hresp),
    .front_panel_lockout_pin(pin_n), .remote_input_one(ri1), .remote_input_two(ri2), .alarm1_out(a1),
    .alarm2_out(a2), .overflow_flash(ovf_fl), .display_strobe(strobe), .alarm_msg_flash(msg),
    .alarm_msg_sel(sel), .display_total(dtot), .irq(irq));
  tal_panel_model i_tal_panel_model (.clk(hclk), .hresetn(hresetn), .lock_req(lock_req),
    .clr_one_req(clr1), .clr_two_req(clr2), .front_panel_lockout_pin(pin_n),
    .remote_input_one(ri1), .remote_input_two(ri2));
  // ==========================================
  task automatic wrap_up;
    $display("fails=%0d compares=%0d", fails, compares);
    if (fails == 0 && compares > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : wrap_up
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      fails++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // one ahb-lite single transfer; address held until hready, then data phase until hready
  task automatic xfer(input logic wr_en, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    @(posedge hclk);
    hsel <= 1'b1; htrans <= 2'h2; hwrite <= wr_en; haddr <= {24'h0, a};
    do @(posedge hclk); while (hready !== 1'b1);
    hsel <= 1'b0; htrans <= 2'h0; hwdata <= d;
    do @(posedge hclk); while (hready !== 1'b1);
    q = hrdata;
  endtask : xfer
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'b1, a, d, v);
  endtask : wr
  task automatic rc(input logic [7:0] a, input logic [31:0] e);
    xfer(1'b0, a, 32'h0, v);
    chk(v, e);
  endtask : rc
  // input stands one second between the two reads: exactly one tick
  task automatic step(input int in, inc);
    logic signed [31:0] a, b, e;
    xfer(1'b0, tal_pkg::REG_TOTAL, 32'h0, a);
    wr(tal_pkg::REG_INPUT, 32'(in));
    repeat (SEC - 3) @(posedge hclk);
    wr(tal_pkg::REG_INPUT, 32'h0);
    xfer(1'b0, tal_pkg::REG_TOTAL, 32'h0, b);
    e = a + inc;
    if (e > 999999 || e < -99999) wraps++;
    if (e > 999999) e = e - 1099999;
    if (e < -99999) e = e + 1099999;
    chk(b, e);
  endtask : step
  task automatic tcase(input int tb, tdp, idp, sc, in, inc);
    wr(tal_pkg::REG_CTRL, tal_pkg::CTRL_RESET | 32'(tb) | 32'(tdp << 2) | 32'(idp << 5));
    wr(tal_pkg::REG_SCALE, 32'(sc));
    step(in, inc);
  endtask : tcase
  task automatic al(input int in, input logic e1, input logic e2);
    wr(tal_pkg::REG_INPUT, 32'(in));
    repeat (5) @(posedge hclk);
    chk({30'h0, a2, a1}, {30'h0, e2, e1});
  endtask : al
  task automatic look(output logic f);
    f = 1'b0;
    repeat (60) begin
      @(posedge hclk);
      #1 if (msg === 1'b1) f = 1'b1;
    end
  endtask : look
  always @(posedge hclk) begin
    cyc++;
    if (cyc == 40000) begin
      fails++;
      $display("ERROR %0t: run too long", $time);
      wrap_up;
    end
  end
  // ==========================================
  initial begin
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    ce <= 1'b0;
    repeat (4) @(posedge hclk);
    ce <= 1'b1;
    rc(tal_pkg::REG_CTRL, tal_pkg::CTRL_RESET);
    rc(tal_pkg::REG_SCALE, 32'd1000);
    rc(tal_pkg::REG_HYST1, 32'd1);
    rc(8'h3c, 32'h0);
    wr(tal_pkg::REG_CUTOUT, -32'sd1000000);
    tcase(0, 0, 0, 1000, 1000, 1000);
    tcase(1, 0, 0, 1000, 6000, 100);
    tcase(2, 0, 0, 1000, 36000, 10);
    tcase(0, 1, 0, 1000, 7, 70);
    tcase(0, 4, 2, 1000, 3, 300);
    tcase(0, 0, 4, 1000, 50000, 5);
    tcase(0, 0, 0, 2000, 100, 200);
    tcase(0, 0, 0, 500, 100, 50);
    tcase(0, 0, 0, 1000, -300, -300);
    wr(tal_pkg::REG_CUTOUT, 32'd500);
    tcase(0, 0, 0, 1000, 100, 0);
    wr(tal_pkg::REG_CUTOUT, -32'sd1000000);
    wr(tal_pkg::REG_CMD, 32'h2);
    wraps = 0;
    step(600000, 600000);
    step(600000, 600000);
    rc(tal_pkg::REG_STATUS, 32'h2 | 32'(wraps & 1));
    chk({31'h0, irq}, 32'h0);
    rc(tal_pkg::REG_IRQ_STAT, 32'h7);
    chk(dtot, 32'd100001);
    wr(tal_pkg::REG_IRQ_EN, 32'h1);
    repeat (2) @(posedge hclk);
    chk({31'h0, irq}, 32'h1);
    wr(tal_pkg::REG_IRQ_CLR, 32'h1);
    repeat (2) @(posedge hclk);
    chk({31'h0, irq}, 32'h0);
    step(-600000, -600000);
    step(-600000, -600000);
    xfer(1'b0, tal_pkg::REG_STATUS, 32'h0, v);
    chk({31'h0, v[0]}, 32'(wraps & 1));
    wr(tal_pkg::REG_SP1, 32'd1000000);
    rc(tal_pkg::REG_SP1, 32'd999999);
    wr(tal_pkg::REG_SP2, -32'sd100000);
    rc(tal_pkg::REG_SP2, -32'sd99999);
    wr(tal_pkg::REG_HYST1, 32'h0);
    rc(tal_pkg::REG_HYST1, 32'd1);
    wr(tal_pkg::REG_HYST1, 32'd100000);
    rc(tal_pkg::REG_HYST1, 32'd99999);
    wr(tal_pkg::REG_CTRL, tal_pkg::CTRL_RESET | (32'h1 << tal_pkg::CTRL_LATCH1));
    wr(tal_pkg::REG_HYST1, 32'd5);
    rc(tal_pkg::REG_HYST1, 32'd99999);
    wr(tal_pkg::REG_CTRL, tal_pkg::CTRL_RESET | (32'h1 << tal_pkg::CTRL_TRACK));
    wr(tal_pkg::REG_SP1, 32'd100);
    wr(tal_pkg::REG_SP2, 32'd200);
    wr(tal_pkg::REG_SP2, 32'd300);
    rc(tal_pkg::REG_SP1, 32'd100);
    lock_req <= 1'b1;
    repeat (5) @(posedge hclk);
    wr(tal_pkg::REG_SP2, 32'd400);
    rc(tal_pkg::REG_SP1, 32'd200);
    lock_req <= 1'b0;
    wr(tal_pkg::REG_CTRL, tal_pkg::CTRL_RESET | (32'h3 << tal_pkg::CTRL_DISPALM) | (32'h1 << tal_pkg::CTRL_TRACK));
    repeat (5) @(posedge hclk);
    wr(tal_pkg::REG_SP2, 32'd500);
    rc(tal_pkg::REG_SP1, 32'd300);
    wr(tal_pkg::REG_CTRL, tal_pkg::CTRL_RESET | (32'h1 << tal_pkg::CTRL_DISPALM));
    wr(tal_pkg::REG_SP1, 32'd100);
    wr(tal_pkg::REG_HYST1, 32'd10);
    wr(tal_pkg::REG_SP2, 32'd50);
    al(101, 1'b1, 1'b0);
    look(seen);
    chk({31'h0, seen}, 32'h1);
    chk({30'h0, sel}, 32'h1);
    al(95, 1'b1, 1'b0);
    al(89, 1'b0, 1'b0);
    look(seen);
    chk({31'h0, seen}, 32'h0);
    al(100, 1'b0, 1'b0);
    al(49, 1'b0, 1'b1);
    al(51, 1'b0, 1'b1);
    al(52, 1'b0, 1'b0);
    wr(tal_pkg::REG_CTRL, tal_pkg::CTRL_RESET | (32'h1 << tal_pkg::CTRL_LATCH1));
    for (int k = 0; k < 3; k++) begin
      al(200, 1'b1, 1'b0);
      wr(tal_pkg::REG_INPUT, 32'd80);
      repeat (5) @(posedge hclk);
      chk({31'h0, a1}, 32'h1);
      if (k == 0) clr1 <= 1'b1;
      else if (k == 1) clr2 <= 1'b1;
      else wr(tal_pkg::REG_CMD, 32'h1);
      @(posedge hclk);
      clr1 <= 1'b0;
      clr2 <= 1'b0;
      repeat (12) @(posedge hclk);
      chk({31'h0, a1}, 32'h0);
    end
    wr(tal_pkg::REG_CUTOUT, 32'd1000);
    wr(tal_pkg::REG_CMD, 32'h2);
    wr(tal_pkg::REG_CTRL, tal_pkg::CTRL_RESET | (32'h1 << tal_pkg::CTRL_SRC1));
    al(200, 1'b0, 1'b0);
    wr(tal_pkg::REG_CTRL, (tal_pkg::CTRL_RESET ^ (32'h1 << tal_pkg::CTRL_TOT_OPT)) | (32'h1 << tal_pkg::CTRL_SRC1));
    al(200, 1'b1, 1'b0);
    wrap_up;
  end
endmodule : tb_tal_top
